// ==== pmbr_map.vh ====
// Command codes, field layouts, reset values and timing for the limit/config bank
`ifndef PMBR_MAP_VH
`define PMBR_MAP_VH

`define PMBR_CMD_VOUT_FLOOR 8'h2B
`define PMBR_CMD_FREQ 8'h33
`define PMBR_CMD_INPUT_TURN_ON_THRESHOLD 8'h35
`define PMBR_CMD_INPUT_TURN_OFF_THRESHOLD 8'h36
`define PMBR_CMD_IOUT_OFS 8'h39
`define PMBR_CMD_OV_LIMIT 8'h40

`define PMBR_FREQ_EXP 5'h07
`define PMBR_VIN_EXP 5'h00
`define PMBR_IOFS_EXP 5'h1E

`define PMBR_FLOOR_MSB 11
`define PMBR_MAN_MSB 3
`define PMBR_OVL_MSB 10

`define PMBR_FLOOR_VALID_LO 12'h000
`define PMBR_FLOOR_VALID_HI 12'hFFF
`define PMBR_FLOOR_RST 12'h000
`define PMBR_FREQ_MAN_RST 4'h7
`define PMBR_INPUT_TURN_ON_THRESHOLD_RST 4'h3
`define PMBR_INPUT_TURN_OFF_THRESHOLD_RST 4'h0
`define PMBR_IOFS_RST 4'h0
`define PMBR_OVL_RST 11'h000

`define PMBR_OVL_STEP1 11'h248
`define PMBR_OVL_STEP2 11'h25C
`define PMBR_OVL_STEP3 11'h29A

`define PMBR_OV_RETRY_MS 52
`define PMBR_CLK_KHZ 100000
`define PMBR_RETRY_W 23

`endif

// ==== pmbr_thresh.v ====
// Input turn-on and turn-off threshold decode, in units of 0.1 V
`timescale 1ns/10ps
`default_nettype none
module pmbr_thresh (
  input wire [3:0] on_man,
  input wire [3:0] off_man,
  output reg [7:0] on_dv,
  output reg [7:0] off_dv
);
  always @*
  begin
    if (on_man >= 4'hA)
      on_dv = 8'h64;
    else if (on_man >= 4'h5)
      on_dv = {4'h0, on_man} * 8'h0A;
    else if (on_man >= 4'h3)
      on_dv = 8'h26;
    else
      on_dv = 8'h19;
    if (off_man >= 4'hA)
      off_dv = 8'h5F;
    else if (off_man >= 4'h6)
      off_dv = {4'h0, off_man} * 8'h0A - 8'h05;
    else if (off_man == 4'h5)
      off_dv = 8'h2A;
    else if (off_man >= 4'h3)
      off_dv = 8'h24;
    else
      off_dv = 8'h17;
  end
endmodule
`default_nettype wire

// ==== pmbr_ovdet.v ====
// Tracking output overvoltage detection and its shutdown / retry response
`timescale 1ns/10ps
`default_nettype none
`include "pmbr_map.vh"
module pmbr_ovdet #(
  parameter RETRY_CYC = `PMBR_OV_RETRY_MS * `PMBR_CLK_KHZ
) (
  input wire clk,
  input wire rst,
  input wire [10:0] limit,
  input wire [11:0] vout_cmd,
  input wire [11:0] vout_sense,
  input wire ss_done,
  input wire [7:0] resp,
  input wire clear,
  output reg fault_r,
  output reg shutdown_r
);
  localparam integer RETRY_LAST_I = RETRY_CYC - 1;
  localparam [`PMBR_RETRY_W-1:0] RETRY_LAST = RETRY_LAST_I[`PMBR_RETRY_W-1:0];
  reg [6:0] pct;
  reg pend_r;
  reg wait_r;
  reg [`PMBR_RETRY_W-1:0] cnt_r;
  wire over;
  always @*
  begin
    if (limit < `PMBR_OVL_STEP1)
      pct = 7'd12;
    else if (limit < `PMBR_OVL_STEP2)
      pct = 7'd16;
    else if (limit < `PMBR_OVL_STEP3)
      pct = 7'd20;
    else
      pct = 7'd50;
  end
  // Compare sense*100 against cmd*(100+pct) to stay in integers; 100+50 needs 8 bits
  assign over = ss_done
    && ({8'h00, vout_sense} * 20'd100 > {8'h00, vout_cmd} * {12'h000, 8'd100 + {1'b0, pct}});
  always @(posedge clk)
  begin
    if (rst)
    begin
      fault_r <= 1'b0;
      pend_r <= 1'b0;
      shutdown_r <= 1'b0;
      wait_r <= 1'b0;
      cnt_r <= {`PMBR_RETRY_W{1'b0}};
    end
    else
    begin
      fault_r <= over | (fault_r & ~clear);
      // Faults seen while already shut down are not queued, so a retry never restarts into one
      pend_r <= (over & ~shutdown_r) | (pend_r & ~clear & ~resp[7]);
      // A fault held while ignored is acted on once shutdown gets enabled
      if (pend_r && resp[7] && !shutdown_r)
      begin
        shutdown_r <= 1'b1;
        wait_r <= (resp[5:3] == 3'b111);
        cnt_r <= {`PMBR_RETRY_W{1'b0}};
      end
      else if (shutdown_r && wait_r)
      begin
        if (cnt_r == RETRY_LAST)
        begin
          shutdown_r <= 1'b0;
          wait_r <= 1'b0;
        end
        cnt_r <= cnt_r + 1'b1;
      end
      else if (shutdown_r && clear)
        shutdown_r <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== pmbr_regs.v ====
// Limit and configuration command bank of the buck converter, with its responses
`timescale 1ns/10ps
`default_nettype none
`include "pmbr_map.vh"
module pmbr_regs #(
  parameter OV_RETRY_CYC = `PMBR_OV_RETRY_MS * `PMBR_CLK_KHZ
) (
  input wire clk,
  input wire rst,
  input wire cmd_valid,
  input wire cmd_write,
  input wire [7:0] cmd_code,
  input wire [15:0] cmd_wdata,
  output reg rsp_valid_r,
  output reg [15:0] rsp_data_r,
  input wire nvm_restore,
  input wire [7:0] nvm_code,
  input wire [15:0] nvm_data,
  input wire [1:0] frequency_strap_pin,
  input wire clear_faults,
  input wire converting,
  input wire enable_ok,
  input wire [7:0] vin_sense_dv,
  input wire target_change,
  input wire [11:0] vout_target,
  input wire [10:0] iout_meas,
  input wire [11:0] vout_cmd,
  input wire [11:0] output_sense_diff,
  input wire soft_start_done,
  input wire [7:0] overvoltage_response_setting,
  output reg [11:0] vout_setpoint_r,
  output reg clamp_active_r,
  output reg [2:0] freq_sel_r,
  output reg [10:0] iout_report_r,
  output reg conv_run_r,
  output reg none_of_above_r,
  output reg status_word_vout_r,
  output reg output_limit_warning_bit_r,
  output reg invalid_data_r,
  output reg unsupported_cmd_r,
  output reg input_undervoltage_fault_r,
  output wire ov_fault_r,
  output wire ov_shutdown_r,
  output reg alert_n_r
);
  reg [11:0] floor_r;
  reg [3:0] freq_man_r;
  reg [3:0] von_man_r;
  reg [3:0] voff_man_r;
  reg [3:0] iofs_man_r;
  reg [10:0] ovl_r;
  reg [11:0] req_target_r;
  reg strap_done_r;
  reg vin_armed_r;
  reg [15:0] rd_word;
  reg [3:0] strap_man;
  reg [2:0] freq_idx;
  reg wr_any;
  reg wr_host;
  reg [7:0] wr_code;
  reg [15:0] wr_data;
  reg floor_bad;
  reg freq_bad;
  reg code_known;
  reg [12:0] iout_sum;
  wire [7:0] on_dv;
  wire [7:0] off_dv;
  wire floor_wr_ok;
  wire floor_low_evt;
  wire floor_raise_evt;
  wire warn_evt;
  wire invalid_evt;
  wire unsup_evt;
  wire uvf_evt;

  // Restore from NVM takes the write path; a host write in the same cycle is dropped
  always @*
  begin
    wr_host = cmd_valid && cmd_write && !nvm_restore;
    wr_any = nvm_restore || wr_host;
    wr_code = nvm_restore ? nvm_code : cmd_code;
    wr_data = nvm_restore ? nvm_data : cmd_wdata;
  end

  always @*
  begin
    case (wr_code)
      `PMBR_CMD_VOUT_FLOOR, `PMBR_CMD_FREQ, `PMBR_CMD_INPUT_TURN_ON_THRESHOLD, `PMBR_CMD_INPUT_TURN_OFF_THRESHOLD,
      `PMBR_CMD_IOUT_OFS, `PMBR_CMD_OV_LIMIT:
        code_known = 1'b1;
      default:
        code_known = 1'b0;
    endcase
    floor_bad = (wr_data[15:12] != 4'h0) || (wr_data[11:0] < `PMBR_FLOOR_VALID_LO)
      || (wr_data[11:0] > `PMBR_FLOOR_VALID_HI);
    // A value too large for the 4-bit mantissa is out of range
    freq_bad = (wr_data[10:4] != 7'h00);
  end

  assign floor_wr_ok = wr_any && (wr_code == `PMBR_CMD_VOUT_FLOOR) && (nvm_restore || !floor_bad);
  assign invalid_evt = wr_host && (((cmd_code == `PMBR_CMD_VOUT_FLOOR) && floor_bad)
    || ((cmd_code == `PMBR_CMD_FREQ) && freq_bad));
  assign unsup_evt = cmd_valid && !nvm_restore && !code_known;

  // Strap frequencies: 0.6, 0.8, 1.0 and 1.4 MHz only
  always @*
  begin
    case (frequency_strap_pin)
      2'b00: strap_man = 4'h4;
      2'b01: strap_man = 4'h6;
      2'b10: strap_man = 4'h7;
      default: strap_man = 4'hA;
    endcase
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      floor_r <= `PMBR_FLOOR_RST;
      freq_man_r <= `PMBR_FREQ_MAN_RST;
      von_man_r <= `PMBR_INPUT_TURN_ON_THRESHOLD_RST;
      voff_man_r <= `PMBR_INPUT_TURN_OFF_THRESHOLD_RST;
      iofs_man_r <= `PMBR_IOFS_RST;
      ovl_r <= `PMBR_OVL_RST;
      strap_done_r <= 1'b0;
    end
    else
    begin
      // Strap is caught on the first cycle after reset release; NVM restore may overwrite it
      if (!strap_done_r)
      begin
        strap_done_r <= 1'b1;
        freq_man_r <= strap_man;
      end
      if (floor_wr_ok)
        floor_r <= wr_data[`PMBR_FLOOR_MSB:0];
      if (wr_any && !(wr_host && freq_bad) && (wr_code == `PMBR_CMD_FREQ))
        freq_man_r <= wr_data[`PMBR_MAN_MSB:0];
      if (wr_any && (wr_code == `PMBR_CMD_INPUT_TURN_ON_THRESHOLD))
        von_man_r <= wr_data[`PMBR_MAN_MSB:0];
      if (wr_any && (wr_code == `PMBR_CMD_INPUT_TURN_OFF_THRESHOLD))
        voff_man_r <= wr_data[`PMBR_MAN_MSB:0];
      if (wr_any && (wr_code == `PMBR_CMD_IOUT_OFS))
        iofs_man_r <= wr_data[`PMBR_MAN_MSB:0];
      if (wr_any && (wr_code == `PMBR_CMD_OV_LIMIT))
        ovl_r <= wr_data[`PMBR_OVL_MSB:0];
    end
  end

  // Fixed exponent and reserved fields are rebuilt on read, never stored
  always @*
  begin
    case (cmd_code)
      `PMBR_CMD_VOUT_FLOOR:
        rd_word = {4'h0, floor_r};
      `PMBR_CMD_FREQ:
        rd_word = {`PMBR_FREQ_EXP, 7'h00, freq_man_r};
      `PMBR_CMD_INPUT_TURN_ON_THRESHOLD:
        rd_word = {`PMBR_VIN_EXP, 7'h00, von_man_r};
      `PMBR_CMD_INPUT_TURN_OFF_THRESHOLD:
        rd_word = {`PMBR_VIN_EXP, 7'h00, voff_man_r};
      `PMBR_CMD_IOUT_OFS:
        rd_word = {`PMBR_IOFS_EXP, {7{iofs_man_r[3]}}, iofs_man_r};
      `PMBR_CMD_OV_LIMIT:
        rd_word = {5'h00, ovl_r};
      default:
        rd_word = 16'h0000;
    endcase
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      rsp_valid_r <= 1'b0;
      rsp_data_r <= 16'h0000;
    end
    else
    begin
      rsp_valid_r <= cmd_valid && !cmd_write;
      rsp_data_r <= (cmd_valid && !cmd_write) ? rd_word : 16'h0000;
    end
  end

  always @*
  begin
    if (freq_man_r < 4'h4)
      freq_idx = 3'h0;
    else if (freq_man_r < 4'h6)
      freq_idx = 3'h1;
    else if (freq_man_r < 4'h7)
      freq_idx = 3'h2;
    else if (freq_man_r < 4'h9)
      freq_idx = 3'h3;
    else if (freq_man_r < 4'hA)
      freq_idx = 3'h4;
    else if (freq_man_r < 4'hD)
      freq_idx = 3'h5;
    else if (freq_man_r < 4'hF)
      freq_idx = 3'h6;
    else
      freq_idx = 3'h7;
  end

  // Offset shares the 0.25 A step of the measurement
  always @*
  begin
    iout_sum = {2'b00, iout_meas} + {{9{iofs_man_r[3]}}, iofs_man_r};
  end

  // Floor clamp of the output target
  assign floor_low_evt = converting && target_change && (vout_target < floor_r);
  assign floor_raise_evt = converting && floor_wr_ok && !target_change
    && (wr_data[11:0] > req_target_r);
  assign warn_evt = floor_low_evt || floor_raise_evt;

  always @(posedge clk)
  begin
    if (rst)
    begin
      req_target_r <= 12'h000;
      vout_setpoint_r <= 12'h000;
      clamp_active_r <= 1'b0;
    end
    else
    begin
      if (target_change)
        req_target_r <= vout_target;
      // The ramp block moves toward this setpoint at the transition rate
      if (floor_low_evt)
      begin
        vout_setpoint_r <= floor_r;
        clamp_active_r <= 1'b1;
      end
      else if (floor_raise_evt)
      begin
        vout_setpoint_r <= wr_data[11:0];
        clamp_active_r <= 1'b1;
      end
      else if (target_change)
      begin
        vout_setpoint_r <= vout_target;
        clamp_active_r <= 1'b0;
      end
    end
  end

  pmbr_thresh u_thresh (
    .on_man(von_man_r),
    .off_man(voff_man_r),
    .on_dv(on_dv),
    .off_dv(off_dv)
  );

  pmbr_ovdet #(
    .RETRY_CYC(OV_RETRY_CYC)
  ) u_ovdet (
    .clk(clk),
    .rst(rst),
    .limit(ovl_r),
    .vout_cmd(vout_cmd),
    .vout_sense(output_sense_diff),
    .ss_done(soft_start_done),
    .resp(overvoltage_response_setting),
    .clear(clear_faults),
    .fault_r(ov_fault_r),
    .shutdown_r(ov_shutdown_r)
  );

  // Turn-off above turn-on is accepted as is; the hysteresis is then inverted
  assign uvf_evt = vin_armed_r && enable_ok && (vin_sense_dv < off_dv);

  always @(posedge clk)
  begin
    if (rst)
    begin
      vin_armed_r <= 1'b0;
      conv_run_r <= 1'b0;
      freq_sel_r <= 3'h0;
      iout_report_r <= 11'h000;
    end
    else
    begin
      // Only the power-on reset re-arms the mask; enable and NVM traffic leave it alone
      if (vin_sense_dv > on_dv)
        vin_armed_r <= 1'b1;
      if (!enable_ok || ov_shutdown_r || (vin_sense_dv < off_dv))
        conv_run_r <= 1'b0;
      else if (vin_sense_dv > on_dv)
        conv_run_r <= 1'b1;
      freq_sel_r <= freq_idx;
      if (iout_sum[12])
        iout_report_r <= 11'h000;
      else if (iout_sum[11])
        iout_report_r <= 11'h7FF;
      else
        iout_report_r <= iout_sum[10:0];
    end
  end

  // Hardware set wins over a clear arriving in the same cycle
  always @(posedge clk)
  begin
    if (rst)
    begin
      none_of_above_r <= 1'b0;
      status_word_vout_r <= 1'b0;
      output_limit_warning_bit_r <= 1'b0;
      invalid_data_r <= 1'b0;
      unsupported_cmd_r <= 1'b0;
      input_undervoltage_fault_r <= 1'b0;
      alert_n_r <= 1'b1;
    end
    else
    begin
      none_of_above_r <= warn_evt || invalid_evt || unsup_evt
        || (none_of_above_r && !clear_faults);
      status_word_vout_r <= warn_evt || (status_word_vout_r && !clear_faults);
      output_limit_warning_bit_r <= warn_evt
        || (output_limit_warning_bit_r && !clear_faults);
      invalid_data_r <= invalid_evt || (invalid_data_r && !clear_faults);
      unsupported_cmd_r <= unsup_evt || (unsupported_cmd_r && !clear_faults);
      input_undervoltage_fault_r <= uvf_evt
        || (input_undervoltage_fault_r && !clear_faults);
      alert_n_r <= !(warn_evt || invalid_evt || unsup_evt || uvf_evt || ov_fault_r
        || ((none_of_above_r || input_undervoltage_fault_r) && !clear_faults));
    end
  end
endmodule
`default_nettype wire

// ==== pmbr_regs_props.sv ====
// Concurrent checks on the ports of the limit and configuration bank
`timescale 1ns/10ps
`default_nettype none
module pmbr_regs_props (
  input wire clk,
  input wire rst,
  input wire cmd_valid,
  input wire cmd_write,
  input wire [7:0] cmd_code,
  input wire nvm_restore,
  input wire rsp_valid_r,
  input wire [15:0] rsp_data_r,
  input wire clamp_active_r,
  input wire none_of_above_r,
  input wire status_word_vout_r,
  input wire output_limit_warning_bit_r,
  input wire invalid_data_r,
  input wire alert_n_r,
  input wire enable_ok,
  input wire conv_run_r,
  input wire soft_start_done,
  input wire ov_fault_r,
  input wire ov_shutdown_r,
  input wire [7:0] overvoltage_response_setting,
  input wire [10:0] iout_meas,
  input wire [10:0] iout_report_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // A restore in the same cycle drops a host write, but a host read is still answered
  wire rd_go = cmd_valid && !cmd_write && !nvm_restore;
  a_read_answer: assert property (rd_go |=> rsp_valid_r)
    else $error("read got no answer");
  a_freq_fixed: assert property (rd_go && cmd_code == 8'h33 |=> rsp_data_r[15:4] == 12'h380)
    else $error("frequency fixed bits wrong");
  a_vin_fixed: assert property (rd_go && (cmd_code == 8'h35 || cmd_code == 8'h36) |=>
    rsp_data_r[15:4] == 12'h000)
    else $error("threshold fixed bits wrong");
  a_floor_top: assert property (rd_go && cmd_code == 8'h2B |=> rsp_data_r[15:12] == 4'h0)
    else $error("floor top bits not zero");
  a_ofs_sign: assert property (rd_go && cmd_code == 8'h39 |=>
    rsp_data_r[15:4] == {5'h1E, {7{rsp_data_r[3]}}})
    else $error("offset sign bits wrong");
  a_clamp_flags: assert property ($rose(clamp_active_r) |-> none_of_above_r &&
    status_word_vout_r && output_limit_warning_bit_r && !alert_n_r)
    else $error("clamp without its status");
  a_invalid_alert: assert property (invalid_data_r |-> none_of_above_r && !alert_n_r)
    else $error("invalid data not reported");
  a_enable_stop: assert property (!enable_ok |=> !conv_run_r)
    else $error("conversion kept without enable");
  a_ov_gated: assert property (!soft_start_done && !ov_fault_r |=> !ov_fault_r)
    else $error("overvoltage before soft start done");
  a_ov_shut: assert property ($rose(ov_fault_r) && overvoltage_response_setting[7] |=> ov_shutdown_r)
    else $error("overvoltage without shutdown");
  a_iout_band: assert property (!$past(rst) |=>
    ({1'b0, iout_report_r} + 12'h008 >= {1'b0, $past(iout_meas)}) &&
    ({1'b0, iout_report_r} <= {1'b0, $past(iout_meas)} + 12'h007))
    else $error("reported current off its band");
endmodule
`default_nettype wire

// ==== pmbr_host_model.sv ====
// Host side model issuing whole word commands and collecting read answers
`timescale 1ns/10ps
`default_nettype none
module pmbr_host_model (
  input wire logic clk,
  output var logic cmd_valid,
  output var logic cmd_write,
  output var logic [7:0] cmd_code,
  output var logic [15:0] cmd_wdata,
  input wire logic rsp_valid_r,
  input wire logic [15:0] rsp_data_r
);
  initial
  begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
  end
  // Idle lines flip so a stale code is never read as a fresh command
  task automatic idle();
    cmd_valid = 1'b0;
    cmd_code = ~cmd_code;
    cmd_wdata = ~cmd_wdata;
  endtask
  task automatic issue(input logic w, input logic [7:0] c, input logic [15:0] d);
    @(posedge clk);
    #1;
    cmd_valid = 1'b1;
    cmd_write = w;
    cmd_code = c;
    cmd_wdata = d;
    @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d);
    issue(1'b1, c, d);
    idle();
  endtask
  task automatic rd(input logic [7:0] c, output logic [15:0] d, output logic v);
    issue(1'b0, c, ~cmd_wdata);
    d = rsp_data_r;
    v = rsp_valid_r;
    idle();
  endtask
endmodule
`default_nettype wire

// ==== pmbus_vin_vout_limit_config_regs_bench.sv ====
// Self-checking bench for the limit and configuration bank
`timescale 1ns/10ps
`default_nettype none
module pmbus_vin_vout_limit_config_regs_bench;
  logic clk, rst, cmd_valid, cmd_write, rsp_valid_r, nvm_restore, clear_faults, converting;
  logic enable_ok, target_change, soft_start_done, clamp_active_r, conv_run_r, none_of_above_r;
  logic status_word_vout_r, output_limit_warning_bit_r, invalid_data_r, unsupported_cmd_r;
  logic input_undervoltage_fault_r, ov_fault_r, ov_shutdown_r, alert_n_r;
  logic [7:0] cmd_code, nvm_code, vin_sense_dv, overvoltage_response_setting;
  logic [15:0] cmd_wdata, rsp_data_r, nvm_data;
  logic [1:0] frequency_strap_pin;
  logic [11:0] vout_target, vout_cmd, output_sense_diff, vout_setpoint_r;
  logic [10:0] iout_meas, iout_report_r;
  logic [2:0] freq_sel_r;
  logic [15:0] lim [4] = '{16'hFA47, 16'h0248, 16'h025C, 16'h029A};
  logic [11:0] pct [4] = '{12'h00C, 12'h010, 12'h014, 12'h032};
  integer mismatches, checks_done, i;
  // Short retry keeps the run brief
  pmbr_regs #(.OV_RETRY_CYC(20)) pmbr_regs_inst (.clk, .rst, .cmd_valid, .cmd_write,
    .cmd_code, .cmd_wdata, .rsp_valid_r, .rsp_data_r, .nvm_restore, .nvm_code, .nvm_data,
    .frequency_strap_pin, .clear_faults, .converting, .enable_ok, .vin_sense_dv,
    .target_change, .vout_target, .iout_meas, .vout_cmd, .output_sense_diff,
    .soft_start_done, .overvoltage_response_setting, .vout_setpoint_r, .clamp_active_r,
    .freq_sel_r, .iout_report_r, .conv_run_r, .none_of_above_r, .status_word_vout_r,
    .output_limit_warning_bit_r, .invalid_data_r, .unsupported_cmd_r,
    .input_undervoltage_fault_r, .ov_fault_r, .ov_shutdown_r, .alert_n_r);
  pmbr_host_model pmbr_host_model_inst (.clk, .cmd_valid, .cmd_write, .cmd_code, .cmd_wdata,
    .rsp_valid_r, .rsp_data_r);
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic conclude();
    if (mismatches == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic step(input integer n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic rdc(input logic [7:0] c, input logic [15:0] e, input string n);
    logic [15:0] d;
    logic v;
    pmbr_host_model_inst.rd(c, d, v);
    chk("rsp_valid", {15'h0000, v}, 16'h0001);
    chk(n, d, e);
  endtask
  task automatic clr();
    clear_faults = 1'b1;
    step(1);
    clear_faults = 1'b0;
  endtask
  function automatic logic [2:0] fidx(input logic [3:0] m);
    return m < 4 ? 0 : m < 6 ? 1 : m < 7 ? 2 : m < 9 ? 3 : m < 10 ? 4 : m < 13 ? 5 : m < 15 ? 6 : 7;
  endfunction
  task automatic t_reset();
    rdc(8'h2B, 16'h0000, "floor");
    rdc(8'h33, 16'h3807, "freq");
    chk("freq_sel", freq_sel_r, 16'h0003);
    rdc(8'h35, 16'h0003, "input_turn_on_threshold");
    rdc(8'h36, 16'h0000, "input_turn_off_threshold");
    rdc(8'h39, 16'hF000, "ofs");
    chk("alert_n", alert_n_r, 16'h0001);
  endtask
  task automatic t_freq();
    for (i = 0; i < 16; i++)
    begin
      pmbr_host_model_inst.wr(8'h33, {12'hF80, i[3:0]});
      step(1);
      chk("freq_sel", freq_sel_r, fidx(i[3:0]));
      rdc(8'h33, {12'h380, i[3:0]}, "freq");
    end
    pmbr_host_model_inst.wr(8'h33, 16'h3815);
    chk("invalid", {invalid_data_r, none_of_above_r, alert_n_r}, 16'h0006);
    rdc(8'h33, 16'h380F, "freq");
    rdc(8'h77, 16'h0000, "unknown");
    chk("unsupported", unsupported_cmd_r, 16'h0001);
    clr();
    // Restore bypasses the range check that a host write would fail
    nvm_code = 8'h33;
    nvm_data = 16'h0015;
    nvm_restore = 1'b1;
    step(1);
    nvm_restore = 1'b0;
    rdc(8'h33, 16'h3805, "freq_nvm");
    chk("invalid", invalid_data_r, 16'h0000);
  endtask
  task automatic t_floor();
    // The floor clamp only acts during conversion
    converting = 1'b1;
    pmbr_host_model_inst.wr(8'h2B, 16'hF100);
    chk("invalid", invalid_data_r, 16'h0001);
    rdc(8'h2B, 16'h0000, "floor");
    clr();
    pmbr_host_model_inst.wr(8'h2B, 16'h0100);
    chk("setpoint", vout_setpoint_r, 16'h0100);
    chk("status", {clamp_active_r, none_of_above_r, status_word_vout_r,
      output_limit_warning_bit_r, alert_n_r}, 16'h001E);
    rdc(8'h2B, 16'h0100, "floor");
    clr();
    vout_target = 12'h200;
    target_change = 1'b1;
    step(1);
    chk("setpoint", vout_setpoint_r, 16'h0200);
    vout_target = 12'h0FF;
    step(1);
    target_change = 1'b0;
    chk("setpoint", vout_setpoint_r, 16'h0100);
    chk("status", {clamp_active_r, none_of_above_r, status_word_vout_r,
      output_limit_warning_bit_r, alert_n_r}, 16'h001E);
    clr();
  endtask
  task automatic t_vin();
    for (i = 0; i < 32; i++)
    begin
      pmbr_host_model_inst.wr(i < 16 ? 8'h35 : 8'h36, {12'hFFF, i[3:0]});
      rdc(i < 16 ? 8'h35 : 8'h36, {12'h000, i[3:0]}, "vin_thr");
    end
    // Turn-on kept above turn-off so conversion does not chatter
    pmbr_host_model_inst.wr(8'h35, 16'h0005);
    pmbr_host_model_inst.wr(8'h36, 16'h0005);
    step(2);
    chk("uv_masked", input_undervoltage_fault_r, 16'h0000);
    vin_sense_dv = 8'h32;
    step(3);
    chk("conv_run", conv_run_r, 16'h0000);
    vin_sense_dv = 8'h33;
    step(3);
    chk("conv_run", conv_run_r, 16'h0001);
    vin_sense_dv = 8'h2A;
    step(3);
    chk("uv", {input_undervoltage_fault_r, conv_run_r}, 16'h0001);
    vin_sense_dv = 8'h29;
    step(3);
    chk("uv", {input_undervoltage_fault_r, conv_run_r}, 16'h0002);
    vin_sense_dv = 8'h33;
    step(3);
    enable_ok = 1'b0;
    step(2);
    chk("conv_run", conv_run_r, 16'h0000);
    enable_ok = 1'b1;
    clr();
  endtask
  task automatic t_iout();
    pmbr_host_model_inst.wr(8'h39, 16'h0008);
    rdc(8'h39, 16'hF7F8, "ofs");
    iout_meas = 11'h005;
    step(2);
    chk("iout", iout_report_r, 16'h0000);
    iout_meas = 11'h014;
    step(2);
    chk("iout", iout_report_r, 16'h000C);
    pmbr_host_model_inst.wr(8'h39, 16'hFFF7);
    rdc(8'h39, 16'hF007, "ofs");
    chk("iout", iout_report_r, 16'h001B);
    iout_meas = 11'h7FF;
    step(2);
    chk("iout", iout_report_r, 16'h07FF);
  endtask
  task automatic t_ov();
    vout_cmd = 12'h064;
    output_sense_diff = 12'h0C8;
    step(3);
    chk("ov_fault", ov_fault_r, 16'h0000);
    output_sense_diff = 12'h064;
    soft_start_done = 1'b1;
    pmbr_host_model_inst.wr(8'h40, lim[0]);
    rdc(8'h40, 16'h0247, "ov_limit");
    for (i = 0; i < 4; i++)
    begin
      pmbr_host_model_inst.wr(8'h40, lim[i]);
      output_sense_diff = 12'h064 + pct[i];
      step(3);
      chk("ov_fault", ov_fault_r, 16'h0000);
      output_sense_diff = 12'h065 + pct[i];
      step(3);
      chk("ov_fault", ov_fault_r, 16'h0001);
      output_sense_diff = 12'h064;
      clr();
    end
    for (i = 0; i < 2; i++)
    begin
      overvoltage_response_setting = i == 0 ? 8'hB8 : 8'h80;
      output_sense_diff = 12'h097;
      step(3);
      chk("shutdown", {ov_shutdown_r, conv_run_r}, 16'h0002);
      output_sense_diff = 12'h064;
      step(25);
      chk("shutdown", ov_shutdown_r, i);
      clr();
      chk("shutdown", ov_shutdown_r, 16'h0000);
    end
  endtask
  initial
  begin
    mismatches = 0;
    checks_done = 0;
    rst = 1'b1;
    {nvm_restore, clear_faults, converting, target_change, soft_start_done} = 5'h00;
    enable_ok = 1'b1;
    nvm_code = 8'h00;
    nvm_data = 16'h0000;
    frequency_strap_pin = 2'h2;
    vin_sense_dv = 8'h14;
    {vout_target, vout_cmd, output_sense_diff} = 36'h000000000;
    iout_meas = 11'h000;
    overvoltage_response_setting = 8'h00;
    step(16);
    rst = 1'b0;
    step(3);
    t_reset();
    t_freq();
    t_floor();
    t_vin();
    t_iout();
    t_ov();
    conclude();
  end
  initial
  begin
    #80000;
    mismatches++;
    conclude();
  end
endmodule
bind pmbr_regs pmbr_regs_props pmbr_regs_props_inst (.clk, .rst, .cmd_valid, .cmd_write,
  .cmd_code, .nvm_restore, .rsp_valid_r, .rsp_data_r, .clamp_active_r, .none_of_above_r,
  .status_word_vout_r, .output_limit_warning_bit_r, .invalid_data_r, .alert_n_r, .enable_ok,
  .conv_run_r, .soft_start_done, .ov_fault_r, .ov_shutdown_r, .overvoltage_response_setting,
  .iout_meas, .iout_report_r);
`default_nettype wire
